// ===== src/oddp_params.svh
// constants for the object dictionary dump responder
`ifndef ODDP_PARAMS_SVH
`define ODDP_PARAMS_SVH
// ****************************************
// message codes
// ****************************************
`define ODDP_FC_DUMP 8'h65
`define ODDP_FC_OBJ 8'h2B
`define ODDP_FC_ERR 8'h80
`define ODDP_SUB_START 8'h55
`define ODDP_SUB_NEXT 8'hAA
`define ODDP_EXC_EXT 8'hFF
`define ODDP_MEI 8'h0D
`define ODDP_EXC_ABORT 8'hCE
`define ODDP_EXC_PC 8'hAE
`define ODDP_XLEN_ABORT 8'h06
`define ODDP_XLEN_PC 8'h03
`define ODDP_PC_SUPPORTED 8'h85
`define ODDP_PC_RSVD_LO 16'h0078
`define ODDP_PC_RSVD_HI 16'hFF00
`define ODDP_ERR_LEN 32'h0607_0012
`define ODDP_ERR_NO_DATA 32'h0000_0002
`define ODDP_ERR_NO_OBJ 32'h0000_0001
`define ODDP_ERR_CMD 32'h0000_0003
`define ODDP_MAX_FRAMES 8'hFC
// ****************************************
// register map, fields, reset values
// ****************************************
`define ODDP_N_OBJ 8
`define ODDP_REG_CTRL 6'h00
`define ODDP_REG_STATUS 6'h01
`define ODDP_REG_IRQ_STAT 6'h02
`define ODDP_REG_IRQ_MASK 6'h03
`define ODDP_REG_COUNT 6'h04
`define ODDP_REG_SEL 6'h05
`define ODDP_REG_KEY 6'h06
`define ODDP_REG_DATA 6'h07
`define ODDP_CTRL_SEG_LSB 8
`define ODDP_CTRL_RST 4'h8
`define ODDP_STAT_STARTED 8
`define ODDP_STAT_PCF_LSB 12
`define ODDP_KEY_SUB_LSB 16
`define ODDP_KEY_SIZE_LSB 24
`define ODDP_IRQ_SEG 0
`define ODDP_IRQ_END 1
`define ODDP_IRQ_REJ 2
`endif

// ===== src/oddp_pkg.sv
// types shared by the object dictionary dump responder
package oddp_pkg;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] fc;
    logic [7:0] sub;
    logic [7:0] len;
    logic [15:0] pc;
    logic [15:0] index;
    logic [7:0] subidx;
    logic [7:0] rd_len;
  } oddp_req_t;
  typedef struct packed {
    logic [2:0] size;
    logic [7:0] subidx;
    logic [15:0] index;
  } oddp_ent_t;
  typedef struct packed {
    logic write;
    logic counter;
    logic wide;
    logic multi;
  } oddp_pcf_t;
  typedef enum logic [1:0] {
    ODDP_IDLE = 2'b00,
    ODDP_HDR = 2'b01,
    ODDP_FRM = 2'b11,
    ODDP_ERR = 2'b10
  } oddp_state_t;
endpackage

// ===== src/oddp_pc_decode.sv
// protocol-control field decoder
`timescale 1ns/100ps
`include "oddp_params.svh"
module oddp_pc_decode
  import oddp_pkg::*;
(
  input wire logic [15:0] pc,
  output oddp_pcf_t flags,
  output logic unsup
);
  wire logic [15:0] rsvd_mask;
  // one driver for the whole struct keeps strict elaborators content
  assign flags = '{
    write: pc[7], // see RULE5
    counter: pc[2], // see RULE3
    wide: pc[1], // see RULE2
    multi: pc[0] // see RULE1
  };
  // upper byte only exists when the field is two bytes wide
  assign rsvd_mask = pc[1] ? (`ODDP_PC_RSVD_LO | `ODDP_PC_RSVD_HI) : `ODDP_PC_RSVD_LO; // see RULE2
  assign unsup = |(pc & rsvd_mask); // see RULE4
endmodule // oddp_pc_decode

// ===== src/oddp_match.sv
// one dictionary entry compared against a requested key
`timescale 1ns/100ps
module oddp_match
  import oddp_pkg::*;
(
  input oddp_ent_t ent,
  input wire logic valid,
  input wire logic [15:0] index,
  input wire logic [7:0] subidx,
  output logic hit
);
  assign hit = valid && ent.index == index && ent.subidx == subidx;
endmodule // oddp_match

// ===== src/oddp_dump.sv
// object dictionary dump responder with object access checks
`timescale 1ns/100ps
`include "oddp_params.svh"
// Overview of operation
// RULE1 - pc bit0 set on all but last part
// RULE2 - pc bit1 selects one or two bytes
// RULE3 - pc bit2 flags a counter byte
// RULE4 - master keeps bits 3-6, 8-15 zero
// RULE5 - pc bit7: read zero, write one
// RULE6 - over-long read gets exception response
// RULE7 - code 65 hex dumps whole dictionary
// RULE8 - subfunction 55 restarts at object zero
// RULE9 - master continues with subfunction AA
// RULE10 - exhausted dump answers no-data error
// RULE11 - request: address, code, sub, 00, check
// RULE12 - response echoes header, length, frames
// RULE13 - frame: index lo, hi, sub, count, data
// RULE14 - error: code+80, FF, length, 0D, CE, code
// RULE15 - bad option bits get AE plus support
// RULE16 - pointer advances; early continue restarts
module oddp_dump
  import oddp_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic req_valid,
  output logic req_ready,
  input oddp_req_t req,
  output logic rsp_valid,
  input wire logic rsp_ready,
  output logic [7:0] rsp_data,
  output logic rsp_last,
  output logic acc_ok,
  output logic [31:0] acc_data,
  output logic irq
);
  // ****************************************
  // state
  // ****************************************
  oddp_state_t st_r, st_nxt;
  oddp_ent_t ent_r [`ODDP_N_OBJ];
  logic [31:0] data_r [`ODDP_N_OBJ];
  logic [3:0] count_r, ptr_r, base_r, obj_r, seg_r, sel_r;
  logic [2:0] fb_r;
  logic [3:0] idx_r;
  logic [23:0] hdr_r;
  logic started_r, err_ae_r, bus_ack_r, out_v_r, out_last_r, acc_ok_r;
  logic [31:0] err_code_r, rdata_r, acc_data_r;
  logic [7:0] out_d_r;
  logic [2:0] irq_stat_r, irq_mask_r;
  oddp_pcf_t pcf_r;
  // ****************************************
  // request decode
  // ****************************************
  oddp_pcf_t pcf;
  logic unsup, too_long, hit_any;
  logic [`ODDP_N_OBJ-1:0] hit;
  logic [2:0] hit_idx;
  wire logic acc = req_valid && req_ready;
  wire logic is_dump = req.fc == `ODDP_FC_DUMP; // see RULE7
  wire logic is_obj = req.fc == `ODDP_FC_OBJ;
  wire logic is_start = req.sub == `ODDP_SUB_START;
  // malformed dump request: nonzero length or unknown subfunction
  wire logic dump_bad = req.len != 8'h00 || (!is_start && req.sub != `ODDP_SUB_NEXT); // see RULE11
  // a continue with no prior start is served as a fresh start
  wire logic [3:0] eff_base = (is_start || !started_r) ? 4'h0 : ptr_r; // see RULE8 RULE16
  wire logic nodata = eff_base >= count_r; // see RULE10
  oddp_pc_decode u_pc (
    .pc(req.pc),
    .flags(pcf),
    .unsup(unsup)
  );
  genvar g;
  generate
    for (g = 0; g < `ODDP_N_OBJ; g++)
    begin : g_match
      oddp_match u_m (
        .ent(ent_r[g]),
        .valid(4'(g) < count_r),
        .index(req.index),
        .subidx(req.subidx),
        .hit(hit[g])
      );
    end
  endgenerate
  always_comb
  begin
    hit_idx = 3'h0;
    for (int i = `ODDP_N_OBJ - 1; i >= 0; i--)
      if (hit[i])
        hit_idx = 3'(i);
  end
  assign hit_any = |hit;
  assign too_long = req.rd_len > 8'(ent_r[hit_idx].size); // see RULE6
  wire logic obj_bad = unsup || (!pcf.write && (!hit_any || too_long));
  wire logic go_err = is_dump ? (dump_bad || nodata) : (is_obj ? obj_bad : 1'b1);
  wire logic go_ae = is_obj && unsup; // see RULE15
  wire logic [31:0] err_code_w = is_dump ? (dump_bad ? `ODDP_ERR_CMD : `ODDP_ERR_NO_DATA)
    : (is_obj ? (hit_any ? `ODDP_ERR_LEN : `ODDP_ERR_NO_OBJ) : `ODDP_ERR_CMD);
  // ****************************************
  // segment sizing
  // ****************************************
  logic [7:0] len_w;
  wire logic [3:0] seg_eff = (seg_r == 4'h0) ? 4'h1 : seg_r;
  wire logic [4:0] seg_sum = {1'b0, base_r} + {1'b0, seg_eff};
  wire logic [3:0] seg_end = (seg_sum > {1'b0, count_r}) ? count_r : seg_sum[3:0];
  always_comb
  begin
    len_w = 8'h00;
    for (int i = 0; i < `ODDP_N_OBJ; i++)
      if (4'(i) >= base_r && 4'(i) < seg_end)
        len_w = len_w + 8'(ent_r[i].size) + 8'h04;
  end
  // ****************************************
  // byte generator
  // ****************************************
  oddp_ent_t cur;
  logic [7:0] gen_byte;
  logic gen_last;
  assign cur = ent_r[obj_r[2:0]];
  wire logic [31:0] cur_data = data_r[obj_r[2:0]];
  wire logic frame_end = {1'b0, fb_r} == 4'(cur.size) + 4'h3;
  wire logic gen_v = st_r != ODDP_IDLE;
  wire logic take = gen_v && (!out_v_r || rsp_ready);
  always_comb
  begin
    gen_byte = 8'h00;
    gen_last = 1'b0;
    unique case (st_r)
      ODDP_IDLE: gen_byte = 8'h00;
      ODDP_HDR:
        unique case (idx_r[1:0]) // see RULE12
          2'h0: gen_byte = hdr_r[23:16];
          2'h1: gen_byte = hdr_r[15:8];
          2'h2: gen_byte = hdr_r[7:0];
          2'h3: gen_byte = len_w;
        endcase
      ODDP_FRM:
      begin
        unique case (fb_r) // see RULE13
          3'h0: gen_byte = cur.index[7:0];
          3'h1: gen_byte = cur.index[15:8];
          3'h2: gen_byte = cur.subidx;
          3'h3: gen_byte = {5'h00, cur.size};
          default: gen_byte = cur_data[{fb_r[1:0], 3'h0} +: 8];
        endcase
        gen_last = frame_end && obj_r + 4'h1 == seg_end;
      end
      ODDP_ERR:
      begin
        case (idx_r) // see RULE14 RULE15
          4'h0: gen_byte = hdr_r[23:16];
          4'h1: gen_byte = hdr_r[15:8] | `ODDP_FC_ERR;
          4'h2: gen_byte = `ODDP_EXC_EXT;
          4'h3: gen_byte = 8'h00;
          4'h4: gen_byte = err_ae_r ? `ODDP_XLEN_PC : `ODDP_XLEN_ABORT;
          4'h5: gen_byte = `ODDP_MEI;
          4'h6: gen_byte = err_ae_r ? `ODDP_EXC_PC : `ODDP_EXC_ABORT;
          4'h7: gen_byte = err_ae_r ? `ODDP_PC_SUPPORTED : err_code_r[7:0];
          4'h8: gen_byte = err_code_r[15:8];
          4'h9: gen_byte = err_code_r[23:16];
          default: gen_byte = err_code_r[31:24];
        endcase
        gen_last = err_ae_r ? idx_r == 4'h7 : idx_r == 4'hA;
      end
    endcase
  end
  // ****************************************
  // sequencer
  // ****************************************
  always_comb
  begin
    st_nxt = st_r;
    unique case (st_r)
      ODDP_IDLE:
        if (acc && go_err)
          st_nxt = ODDP_ERR;
        else if (acc && is_dump)
          st_nxt = ODDP_HDR;
      ODDP_HDR:
        if (take && idx_r == 4'h3)
          st_nxt = ODDP_FRM;
      ODDP_FRM, ODDP_ERR:
        if (take && gen_last)
          st_nxt = ODDP_IDLE;
    endcase
  end
  assign req_ready = st_r == ODDP_IDLE;
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_r <= ODDP_IDLE;
      idx_r <= 4'h0;
      fb_r <= 3'h0;
      obj_r <= 4'h0;
      base_r <= 4'h0;
      hdr_r <= 24'h00_0000;
      err_ae_r <= 1'b0;
      err_code_r <= 32'h0000_0000;
      pcf_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
      if (acc)
      begin
        idx_r <= 4'h0;
        fb_r <= 3'h0;
        obj_r <= eff_base;
        base_r <= eff_base;
        hdr_r <= {req.addr, req.fc, req.sub};
        err_ae_r <= go_ae;
        err_code_r <= err_code_w;
        if (is_obj)
          pcf_r <= pcf; // see RULE1 RULE2 RULE3 RULE5
      end
      else if (take && st_r == ODDP_FRM)
      begin
        fb_r <= frame_end ? 3'h0 : fb_r + 3'h1;
        if (frame_end)
          obj_r <= obj_r + 4'h1;
      end
      else if (take)
        idx_r <= idx_r + 4'h1;
    end
  end
  // ****************************************
  // dump pointer and output stage
  // ****************************************
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ptr_r <= 4'h0;
      started_r <= 1'b0;
      out_v_r <= 1'b0;
      out_d_r <= 8'h00;
      out_last_r <= 1'b0;
      acc_ok_r <= 1'b0;
      acc_data_r <= 32'h0000_0000;
    end
    else
    begin
      if (acc && is_dump && !dump_bad)
      begin
        started_r <= 1'b1;
        ptr_r <= eff_base; // see RULE8
      end
      else if (take && gen_last && st_r == ODDP_FRM)
        ptr_r <= seg_end; // see RULE16
      if (take)
      begin
        out_v_r <= 1'b1;
        out_d_r <= gen_byte;
        out_last_r <= gen_last;
      end
      else if (rsp_ready)
        out_v_r <= 1'b0;
      acc_ok_r <= acc && is_obj && !go_err;
      if (acc && is_obj && !go_err)
        acc_data_r <= data_r[hit_idx];
    end
  end
  assign rsp_valid = out_v_r;
  assign rsp_data = out_d_r;
  assign rsp_last = out_last_r;
  assign acc_ok = acc_ok_r;
  assign acc_data = acc_data_r;
  // ****************************************
  // register slave and interrupt
  // ****************************************
  wire logic [5:0] wa = avs_address[7:2];
  wire logic bus_req = avs_read || avs_write;
  wire logic wr = avs_write && bus_ack_r;
  wire logic [2:0] ev = {acc && go_err && !(is_dump && !dump_bad && nodata),
    acc && is_dump && !dump_bad && nodata, take && gen_last && st_r == ODDP_FRM};
  wire logic [2:0] w1c = (wr && wa == `ODDP_REG_IRQ_STAT) ? avs_writedata[2:0] : 3'h0;
  logic [31:0] rmux;
  always_comb
  begin
    unique case (wa)
      `ODDP_REG_CTRL: rmux = {20'h0_0000, seg_r, 8'h00};
      `ODDP_REG_STATUS: rmux = {16'h0000, pcf_r, 3'h0, started_r, 4'h0, ptr_r};
      `ODDP_REG_IRQ_STAT: rmux = {29'h0, irq_stat_r};
      `ODDP_REG_IRQ_MASK: rmux = {29'h0, irq_mask_r};
      `ODDP_REG_COUNT: rmux = {28'h000_0000, count_r};
      `ODDP_REG_SEL: rmux = {28'h000_0000, sel_r};
      `ODDP_REG_KEY: rmux = {5'h00, ent_r[sel_r[2:0]]};
      `ODDP_REG_DATA: rmux = data_r[sel_r[2:0]];
      default: rmux = 32'h0000_0000;
    endcase
  end
  assign avs_waitrequest = bus_req && !bus_ack_r;
  assign avs_readdata = rdata_r;
  assign irq = |(irq_stat_r & irq_mask_r);
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      bus_ack_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      seg_r <= `ODDP_CTRL_RST;
      count_r <= 4'h0;
      sel_r <= 4'h0;
      irq_stat_r <= 3'h0;
      irq_mask_r <= 3'h0;
    end
    else
    begin
      bus_ack_r <= bus_req && !bus_ack_r;
      if (avs_read && !bus_ack_r)
        rdata_r <= rmux;
      // a fresh event outranks a same-cycle clear
      irq_stat_r <= (irq_stat_r & ~w1c) | ev;
      if (wr && wa == `ODDP_REG_CTRL)
        seg_r <= avs_writedata[`ODDP_CTRL_SEG_LSB +: 4];
      if (wr && wa == `ODDP_REG_IRQ_MASK)
        irq_mask_r <= avs_writedata[2:0];
      if (wr && wa == `ODDP_REG_COUNT)
        count_r <= (avs_writedata[3:0] > 4'h8) ? 4'h8 : avs_writedata[3:0];
      if (wr && wa == `ODDP_REG_SEL)
        sel_r <= {1'b0, avs_writedata[2:0]};
    end
  end
  // dictionary storage, no reset needed beyond a known value
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (int i = 0; i < `ODDP_N_OBJ; i++)
      begin
        ent_r[i] <= '0;
        data_r[i] <= 32'h0000_0000;
      end
    end
    else if (wr && wa == `ODDP_REG_KEY)
      ent_r[sel_r[2:0]] <= avs_writedata[26:0];
    else if (wr && wa == `ODDP_REG_DATA)
      data_r[sel_r[2:0]] <= avs_writedata;
  end
  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  sequence s_obj_acc;
    acc && is_obj;
  endsequence
  sequence s_dump_acc;
    acc && is_dump && !dump_bad;
  endsequence
  pc_reject_ae_a: assert property (s_obj_acc ##0 unsup |=> st_r == ODDP_ERR && err_ae_r) // see RULE15
    else $error("unsupported option not answered with AE");
  len_reject_a: assert property (s_obj_acc ##0 (!unsup && !pcf.write && hit_any && too_long) // see RULE6
    |=> st_r == ODDP_ERR && err_code_r == `ODDP_ERR_LEN)
    else $error("over-long read not rejected");
  pc_flags_a: assert property (s_obj_acc |=> pcf_r == {$past(req.pc[7]), $past(req.pc[2]), // see RULE1
    $past(req.pc[1]), $past(req.pc[0])})
    else $error("protocol control flags misdecoded");
  start_zero_a: assert property (s_dump_acc ##0 is_start ##0 count_r != 4'h0 // see RULE8
    |=> st_r == ODDP_HDR && obj_r == 4'h0 && ptr_r == 4'h0)
    else $error("start did not rewind to object zero");
  no_data_a: assert property (s_dump_acc ##0 nodata |=> st_r == ODDP_ERR // see RULE10
    && err_code_r == `ODDP_ERR_NO_DATA && !err_ae_r)
    else $error("exhausted dump not answered with no-data");
  err_fc_a: assert property (st_r == ODDP_ERR && take && idx_r == 4'h1 // see RULE14
    |=> out_d_r == (hdr_r[15:8] | `ODDP_FC_ERR) && out_v_r)
    else $error("error function code not offset");
  seg_len_a: assert property (st_r == ODDP_HDR && take && idx_r == 4'h3 // see RULE12
    |=> out_d_r >= 8'h04 && out_d_r <= `ODDP_MAX_FRAMES ##1 st_r == ODDP_FRM)
    else $error("segment length out of range");
  ptr_adv_a: assert property (st_r == ODDP_FRM && take && gen_last |=> ptr_r == $past(seg_end) // see RULE16
    && st_r == ODDP_IDLE && out_last_r)
    else $error("dump pointer not advanced");
  bus_wait_a: assert property (bus_req && !bus_ack_r |-> ##[1:2] !avs_waitrequest)
    else $error("register access not answered");
endmodule // oddp_dump

// ===== verif/oddp_master.sv
// remote fieldbus master model: issues requests and gathers response bytes
`timescale 1ns/100ps
module oddp_master
  import oddp_pkg::*;
(
  input wire logic mclk,
  output logic req_valid,
  input wire logic req_ready,
  output oddp_req_t req,
  input wire logic rsp_valid,
  output logic rsp_ready,
  input wire logic [7:0] rsp_data,
  input wire logic rsp_last,
  input wire logic acc_ok
);
  logic [7:0] got[$];
  logic done;
  logic acc_seen;
  logic slow;
  logic hung;
  initial
  begin
    req_valid = 1'b0;
    req = '0;
    rsp_ready = 1'b1;
    done = 1'b0;
    acc_seen = 1'b0;
    slow = 1'b0;
    hung = 1'b0;
  end
  // a slow master stalls every other cycle so each byte must stand
  always @(posedge mclk)
  begin
    rsp_ready <= slow ? ~rsp_ready : 1'b1;
    if (rsp_valid && rsp_ready)
    begin
      got.push_back(rsp_data);
      if (rsp_last)
        done <= 1'b1;
    end
    if (acc_ok)
      acc_seen <= 1'b1;
  end
  task automatic send(input oddp_req_t r);
    int i;
    got.delete();
    done = 1'b0;
    acc_seen = 1'b0;
    req <= r;
    req_valid <= 1'b1;
    for (i = 0; i < 100; i++)
    begin
      @(posedge mclk);
      if (req_ready === 1'b1)
        break;
    end
    if (i == 100)
      hung = 1'b1;
    req_valid <= 1'b0;
    // released request lines must not look like a held request
    req <= ~r;
  endtask
  task automatic dump(input logic [7:0] sub);
    send('{addr: 8'h11, fc: 8'h65, sub: sub, len: 8'h00, default: '0});
  endtask
  task automatic obj(input logic [15:0] pc, input logic [15:0] idx, input logic [7:0] n);
    send('{addr: 8'h11, fc: 8'h2B, sub: 8'h0D, len: 8'h00, pc: pc, index: idx,
      subidx: 8'h00, rd_len: n});
  endtask
endmodule // oddp_master

// ===== verif/oddp_dump_tb.sv
// self-checking bench for the object dictionary dump responder
`timescale 1ns/100ps
`include "oddp_params.svh"
module oddp_dump_tb;
  typedef logic [7:0] oddp_bq_t[$];
  logic mclk;
  logic arst_n;
  logic [7:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic req_valid;
  logic req_ready;
  oddp_pkg::oddp_req_t req;
  logic rsp_valid;
  logic rsp_ready;
  logic [7:0] rsp_data;
  logic rsp_last;
  logic acc_ok;
  logic [31:0] acc_data;
  logic irq;
  logic [31:0] rd;
  int n_mismatch = 0;
  int checked = 0;
  oddp_dump dut (.mclk(mclk), .arst_n(arst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .req_valid(req_valid),
    .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready),
    .rsp_data(rsp_data), .rsp_last(rsp_last), .acc_ok(acc_ok), .acc_data(acc_data), .irq(irq));
  oddp_master master (.mclk(mclk), .req_valid(req_valid), .req_ready(req_ready), .req(req),
    .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp_data(rsp_data), .rsp_last(rsp_last),
    .acc_ok(acc_ok));
  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic give_up();
    n_mismatch++;
    tally_and_finish();
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [5:0] w, input logic [31:0] d);
    int i;
    avs_address <= {w, 2'b00};
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    for (i = 0; i < 50; i++)
    begin
      @(posedge mclk);
      if (avs_waitrequest === 1'b0)
        break;
    end
    if (i == 50)
      give_up();
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic expect_rsp(input oddp_bq_t e);
    int i;
    for (i = 0; i < 300; i++)
    begin
      @(posedge mclk);
      if (master.done === 1'b1)
        break;
    end
    if (i == 300 || master.hung)
      give_up();
    check(master.got.size(), e.size());
    foreach (e[k])
      check(master.got[k], e[k]);
  endtask
  task automatic err_rsp(input logic [7:0] fc, input logic [31:0] code);
    expect_rsp('{8'h11, fc | 8'h80, 8'hFF, 8'h00, 8'h06, 8'h0D, 8'hCE, code[7:0], code[15:8],
      code[23:16], code[31:24]});
  endtask
  task automatic acc_pass(input logic [15:0] pc, input logic [3:0] flags);
    master.obj(pc, 16'h6041, 8'h02);
    repeat (3) @(posedge mclk);
    check({31'h0, master.acc_seen}, 32'h1);
    bus(1'b0, `ODDP_REG_STATUS, 32'h0);
    check({28'h0, rd[15:12]}, {28'h0, flags});
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    bus(1'b0, `ODDP_REG_CTRL, 32'h0);
    check(rd, 32'h0000_0800);
    bus(1'b0, `ODDP_REG_COUNT, 32'h0);
    check(rd, 32'h0);
    bus(1'b0, `ODDP_REG_IRQ_MASK, 32'h0);
    check(rd, 32'h0);
    bus(1'b1, 6'h08, 32'hFFFF_FFFF);
    bus(1'b0, 6'h08, 32'h0);
    check(rd, 32'h0);
    check({31'h0, irq}, 32'h0);
    $display("test reset values finished");
  endtask
  task automatic t_empty();
    // continuation with no start yet restarts on an empty dictionary
    master.dump(8'hAA);
    err_rsp(8'h65, 32'h0000_0002);
    $display("test empty dictionary finished");
  endtask
  task automatic t_full();
    bus(1'b1, `ODDP_REG_SEL, 32'h0);
    bus(1'b1, `ODDP_REG_KEY, 32'h0200_6041);
    bus(1'b1, `ODDP_REG_DATA, 32'h0000_0637);
    bus(1'b1, `ODDP_REG_SEL, 32'h1);
    bus(1'b1, `ODDP_REG_KEY, 32'h0100_6061);
    bus(1'b1, `ODDP_REG_DATA, 32'h0000_0005);
    bus(1'b1, `ODDP_REG_COUNT, 32'h2);
    bus(1'b0, `ODDP_REG_KEY, 32'h0);
    check(rd, 32'h0100_6061);
    master.slow = 1'b1;
    master.dump(8'h55);
    expect_rsp('{8'h11, 8'h65, 8'h55, 8'h0B, 8'h41, 8'h60, 8'h00, 8'h02, 8'h37, 8'h06,
      8'h61, 8'h60, 8'h00, 8'h01, 8'h05});
    master.slow = 1'b0;
    master.dump(8'hAA);
    err_rsp(8'h65, 32'h0000_0002);
    bus(1'b0, `ODDP_REG_IRQ_STAT, 32'h0);
    check(rd & 32'h3, 32'h3);
    bus(1'b1, `ODDP_REG_IRQ_MASK, 32'h2);
    check({31'h0, irq}, 32'h1);
    bus(1'b1, `ODDP_REG_IRQ_STAT, 32'h2);
    check({31'h0, irq}, 32'h0);
    bus(1'b0, `ODDP_REG_IRQ_STAT, 32'h0);
    check(rd & 32'h3, 32'h1);
    $display("test full dump finished");
  endtask
  task automatic t_seg();
    bus(1'b1, `ODDP_REG_CTRL, 32'h0000_0100);
    repeat (2)
    begin
      master.dump(8'h55);
      expect_rsp('{8'h11, 8'h65, 8'h55, 8'h06, 8'h41, 8'h60, 8'h00, 8'h02, 8'h37,
        8'h06});
      master.dump(8'hAA);
      expect_rsp('{8'h11, 8'h65, 8'hAA, 8'h05, 8'h61, 8'h60, 8'h00, 8'h01, 8'h05});
      master.dump(8'hAA);
      err_rsp(8'h65, 32'h0000_0002);
      bus(1'b0, `ODDP_REG_STATUS, 32'h0);
      check(rd & 32'h10F, 32'h102);
    end
    $display("test one object per segment finished");
  endtask
  task automatic t_obj();
    master.obj(16'h0020, 16'h6061, 8'h01);
    expect_rsp('{8'h11, 8'hAB, 8'hFF, 8'h00, 8'h03, 8'h0D, 8'hAE, 8'h85});
    master.obj(16'h0102, 16'h6061, 8'h01);
    expect_rsp('{8'h11, 8'hAB, 8'hFF, 8'h00, 8'h03, 8'h0D, 8'hAE, 8'h85});
    master.obj(16'h0000, 16'h6061, 8'h02);
    err_rsp(8'h2B, 32'h0607_0012);
    master.obj(16'h0000, 16'h1234, 8'h01);
    err_rsp(8'h2B, 32'h0000_0001);
    acc_pass(16'h0001, 4'h1);
    acc_pass(16'h0002, 4'h2);
    acc_pass(16'h0004, 4'h4);
    acc_pass(16'h0087, 4'hF);
    check(acc_data, 32'h0000_0637);
    master.dump(8'h33);
    err_rsp(8'h65, 32'h0000_0003);
    master.send('{addr: 8'h33, fc: 8'h65, sub: 8'h55, len: 8'h01, default: '0});
    expect_rsp('{8'h33, 8'hE5, 8'hFF, 8'h00, 8'h06, 8'h0D, 8'hCE, 8'h03, 8'h00, 8'h00,
      8'h00});
    master.send('{addr: 8'h44, fc: 8'h10, default: '0});
    expect_rsp('{8'h44, 8'h90, 8'hFF, 8'h00, 8'h06, 8'h0D, 8'hCE, 8'h03, 8'h00, 8'h00,
      8'h00});
    master.send('{addr: 8'h22, fc: 8'h2B, sub: 8'h0D, len: 8'h00, pc: 16'h0000,
      index: 16'h6041, subidx: 8'h01, rd_len: 8'h01});
    expect_rsp('{8'h22, 8'hAB, 8'hFF, 8'h00, 8'h06, 8'h0D, 8'hCE, 8'h01, 8'h00, 8'h00,
      8'h00});
    bus(1'b0, `ODDP_REG_IRQ_STAT, 32'h0);
    check(rd & 32'h4, 32'h4);
    $display("test object access finished");
  endtask
  task automatic t_rst_mid();
    bus(1'b1, `ODDP_REG_COUNT, 32'h0000_000F);
    bus(1'b0, `ODDP_REG_COUNT, 32'h0);
    check(rd, 32'h0000_0008);
    bus(1'b1, `ODDP_REG_IRQ_MASK, 32'h0000_0007);
    check({31'h0, irq}, 32'h1);
    arst_n <= 1'b0;
    repeat (3) @(posedge mclk);
    check({31'h0, irq}, 32'h0);
    check({31'h0, rsp_valid}, 32'h0);
    arst_n <= 1'b1;
    bus(1'b0, `ODDP_REG_STATUS, 32'h0);
    check(rd, 32'h0);
    bus(1'b0, `ODDP_REG_CTRL, 32'h0);
    check(rd, 32'h0000_0800);
    bus(1'b0, `ODDP_REG_IRQ_MASK, 32'h0);
    check(rd, 32'h0);
    $display("test reset in mid-run finished");
  endtask
  initial
  begin
    arst_n = 1'b0;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    repeat (20) @(posedge mclk);
    arst_n <= 1'b1;
    @(posedge mclk);
    t_reset();
    t_empty();
    t_full();
    t_seg();
    t_obj();
    t_rst_mid();
    tally_and_finish();
  end
endmodule // oddp_dump_tb
